// *** core/rssm_params.svh ***
// Named constants of the reset sequencer and supply monitor.
// Assumes inclusion by bare name from the top module and the bench.
`ifndef RSSM_PARAMS_SVH
`define RSSM_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define RSSM_OFS_ICS        8'h00
`define RSSM_OFS_OPT        8'h04
`define RSSM_OFS_PHASE      8'h08
// Field positions in the integrity control/status register.
`define RSSM_ICS_IE         6
`define RSSM_ICS_FLAG       5
`define RSSM_ICS_UVRF       4
`define RSSM_ICS_WATCHDOG_RESET_FLAG      0
// Option register reset value: short delay, detector on, low level, crystal 1.
`define RSSM_OPT_RESET      8'h12
// Reset vector address pair at the top of memory.
`define RSSM_VEC_LO         16'hFFFE
`define RSSM_VEC_HI         16'hFFFF
// Vector fetch length in clock cycles.
`define RSSM_FETCH_CYC      2
// Clock rate and the least watchdog reset output pulse.
`define RSSM_CLK_MHZ        125
`define RSSM_T_WDG_PULSE_NS 200
`define RSSM_WDG_PULSE_CYC  ((`RSSM_T_WDG_PULSE_NS * `RSSM_CLK_MHZ + 999) / 1000)
// AXI answers.
`define RSSM_RESP_OKAY      2'b00
`define RSSM_RESP_SLVERR    2'b10

`endif

// *** core/rssm_pkg.sv ***
// Types shared by the reset sequencer and supply monitor.
// Assumes nothing beyond the constants header.
package rssm_pkg;

    // Phase of the reset sequence.
    typedef enum logic [1:0] {
        RSSM_ACTIVE,
        RSSM_DELAY,
        RSSM_FETCH,
        RSSM_RUN
    } rssm_phase_t;

    // Option settings, laid out as they sit in the option register.
    typedef struct packed {
        logic       spare;                 // Reads back as written.
        logic [2:0] clock_source_selector; // 0 ext, 1-4 crystal ranges, 5 RC.
        logic [1:0] uv_threshold;          // 0 low, 1 medium, 2 high.
        logic       uv_enable;             // Undervoltage detector present.
        logic       long_delay;            // 1 selects the long delay.
    } rssm_opt_t;

endpackage : rssm_pkg

// *** core/rssm_top.sv ***
// Reset sequence manager with the digital side of the supply supervisors.
// Assumes one 125 MHz clock, comparator outputs from analog macros and an
// open-drain reset pad whose level the surroundings resolve from oe.
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "rssm_params.svh"

// Notes on behaviour
// - Pin, undervoltage or watchdog starts the sequence.
// - Every source drives pin low through delay.
// - Vector fetched from the top address pair.
// - Phases run active, delay, then vector fetch.
// - Delay is 256 or 4096 cycles by option.
// - Vector fetch takes exactly two cycles.
// - Main oscillator keeps running during reset.
// - Low pin level enters reset without filtering.
// - Reset pin is open-drain, both sides pull low.
// - Low supply holds static reset, pin low.
// - Detector enable and threshold chosen by option.
// - Watchdog underflow drives pin for minimum pulse.
// - Warning comparator readable live as flag.
// - Warning works only with detector enabled.
// - Enabled interrupt on every flag toggle while the CPU runs.
// - No warning interrupt for rise within delay.
// - Enable while low gives interrupt at enable.
// - Enable after unreported crossing gives one interrupt.
// - Clock source picked among six by option.
// - Pending interrupt cleared on routine entry.
// - Undervoltage flag set by hardware, cleared by zero.
// - Watchdog flag cleared by zero or undervoltage.
module rssm_top
    import rssm_pkg::*;
#(
    parameter int DELAY_SHORT = 256,
    parameter int DELAY_LONG  = 4096
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic        rst_pin_i,
    output logic             rst_pin_o,
    output logic             rst_pin_oe,
    input  wire logic        uv_low_i,
    input  wire logic        sw_cmp_i,
    input  wire logic        wdg_underflow_i,
    input  wire logic        isr_ack_i,
    output logic             cpu_reset_n,
    output logic             vec_fetch,
    output logic [15:0]      vec_addr,
    output logic             osc_run,
    output logic [2:0]       clock_source_selector,
    output logic [1:0]       uv_threshold_sel,
    output logic             supply_warning_irq
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The delay counter is 13 bits wide, so longer delays cannot be served.
    if (DELAY_SHORT < 1 || DELAY_LONG < 1 || DELAY_SHORT > 8192 || DELAY_LONG > 8192) begin : g_bad
        $error("rssm_top: delay lengths out of range");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    rssm_phase_t phase;            // Current sequence phase.
    rssm_phase_t next_phase;       // Phase for the next cycle.
    rssm_opt_t   opt;              // Option settings.
    logic [12:0] cnt;              // Delay and fetch down-counter.
    logic [12:0] delay_len;        // Selected delay minus one.
    logic [7:0]  wdg_cnt;          // Remaining watchdog pulse cycles.
    logic [1:0]  sync1;            // First synchroniser stage.
    logic [1:0]  sync2;            // Second stage: bit 1 supply, bit 0 warning.
    logic        src_uv;           // Undervoltage reset request.
    logic        src_ext;          // External pin reset request.
    logic        any_src;          // Any reset request.
    logic        sw_flag;          // Supply warning flag.
    logic        sw_new;           // Flag value for the next cycle.
    logic        sw_toggle;        // Flag changes while the CPU runs.
    logic        sw_missed;        // Crossing seen while the interrupt was off.
    logic        supply_warning_irq_enable;
    logic        uv_rf;            // Undervoltage reset flag.
    logic        wdg_rf;           // Watchdog reset flag.
    logic        irq_set;          // Pending interrupt is raised.
    logic        ie_rise;          // Enable bit written from zero to one.
    logic        wr_en;            // Both write halves held, answer due.
    logic [7:0]  aw_addr;          // Held write address.
    logic [7:0]  w_data;           // Held low write byte.
    logic        w_lane0;          // Low byte lane was enabled.
    logic [31:0] rd_val;           // Read data for the decoded address.
    logic        rd_hit;           // Read address is mapped.

    // ------------------------------------------------------------------
    // Comparator synchronisers
    // ------------------------------------------------------------------
    // Both comparators are free running analog outputs, so each passes two
    // flops; only the second stage is looked at by anything else.
    for (genvar i = 0; i < 2; i++) begin : g_sync
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sync1[i] <= 1'b0;
                sync2[i] <= 1'b0;
            end else begin
                sync1[i] <= (i == 1) ? uv_low_i : sw_cmp_i;
                sync2[i] <= sync1[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------------
    always_comb begin
        // The detector only acts when the option enables it.
        src_uv  = opt.uv_enable & sync2[1];
        // Our own drive would read back as low, so the pin counts only
        // while released; the level is taken without any filter.
        src_ext = ~rst_pin_i & ~rst_pin_oe;
        any_src = src_uv | src_ext | wdg_underflow_i;
        delay_len = opt.long_delay ? 13'(DELAY_LONG - 1)
                                   : 13'(DELAY_SHORT - 1);
    end

    // ------------------------------------------------------------------
    // Phase sequencing
    // ------------------------------------------------------------------
    // Decide the next phase from the current one and the sources.
    always_comb begin
        next_phase = phase;
        case (phase)
            RSSM_ACTIVE: begin
                // Active phase lasts while any source stands or the watchdog pulse runs.
                if (!any_src && wdg_cnt == 8'h00) begin
                    next_phase = RSSM_DELAY;
                end
            end
            RSSM_DELAY: begin
                if (any_src) begin
                    next_phase = RSSM_ACTIVE;
                end else if (cnt == 13'h0000) begin
                    next_phase = RSSM_FETCH;
                end
            end
            RSSM_FETCH: begin
                if (any_src) begin
                    next_phase = RSSM_ACTIVE;
                end else if (cnt == 13'h0000) begin
                    next_phase = RSSM_RUN;
                end
            end
            RSSM_RUN: begin
                if (any_src) begin
                    next_phase = RSSM_ACTIVE;
                end
            end
            default: next_phase = RSSM_ACTIVE;
        endcase
    end

    // Phase register and the shared down-counter.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= RSSM_ACTIVE;
            cnt   <= 13'h0000;
        end else begin
            phase <= next_phase;
            if (next_phase == RSSM_DELAY && phase != RSSM_DELAY) begin
                cnt <= delay_len;
            end else if (next_phase == RSSM_FETCH && phase != RSSM_FETCH) begin
                cnt <= 13'(`RSSM_FETCH_CYC - 1);
            end else if (cnt != 13'h0000) begin
                cnt <= cnt - 13'h0001;
            end
        end
    end

    // Watchdog pulse stretcher keeps the active phase long enough.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdg_cnt <= 8'h00;
        end else if (wdg_underflow_i) begin
            wdg_cnt <= 8'(`RSSM_WDG_PULSE_CYC);
        end else if (wdg_cnt != 8'h00) begin
            wdg_cnt <= wdg_cnt - 8'h01;
        end
    end

    // Pin drive, CPU reset and vector fetch outputs, all registered.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_pin_oe  <= 1'b1;
            cpu_reset_n <= 1'b0;
            vec_fetch   <= 1'b0;
            vec_addr    <= `RSSM_VEC_LO;
        end else begin
            rst_pin_oe  <= (next_phase == RSSM_ACTIVE) ||
                           (next_phase == RSSM_DELAY);
            cpu_reset_n <= (next_phase == RSSM_RUN);
            vec_fetch   <= (next_phase == RSSM_FETCH);
            // Low byte address first, then the high one.
            vec_addr    <= (next_phase == RSSM_FETCH && phase == RSSM_FETCH)
                           ? `RSSM_VEC_HI : `RSSM_VEC_LO;
        end
    end

    // Pad, oscillator and option outputs: the pad only ever pulls low, the oscillator never stops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_pin_o             <= 1'b0;
            osc_run               <= 1'b1;
            clock_source_selector <= 3'h0;
            uv_threshold_sel      <= 2'h0;
        end else begin
            rst_pin_o             <= 1'b0;
            osc_run               <= 1'b1;
            clock_source_selector <= opt.clock_source_selector;
            uv_threshold_sel      <= opt.uv_threshold;
        end
    end

    // ------------------------------------------------------------------
    // Reset cause flags
    // ------------------------------------------------------------------
    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            uv_rf  <= 1'b0;
            wdg_rf <= 1'b0;
        end else begin
            if (src_uv) begin
                uv_rf <= 1'b1;
            end else if (wr_en && w_lane0 && aw_addr == `RSSM_OFS_ICS &&
                         !w_data[`RSSM_ICS_UVRF]) begin
                uv_rf <= 1'b0;
            end
            if (wdg_underflow_i) begin
                wdg_rf <= 1'b1;
            end else if (src_uv) begin
                wdg_rf <= 1'b0;
            end else if (wr_en && w_lane0 && aw_addr == `RSSM_OFS_ICS &&
                         !w_data[`RSSM_ICS_WATCHDOG_RESET_FLAG]) begin
                wdg_rf <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Supply warning
    // ------------------------------------------------------------------
    always_comb begin
        sw_new  = opt.uv_enable & sync2[0];
        ie_rise = wr_en && w_lane0 && aw_addr == `RSSM_OFS_ICS &&
                  w_data[`RSSM_ICS_IE] && !supply_warning_irq_enable;
        // Toggles are only seen once the CPU runs, so a rise inside the
        // delay raises nothing; enabling under the threshold, or after a
        // crossing that went unreported, raises one.
        sw_toggle = phase == RSSM_RUN && sw_new != sw_flag;
        irq_set = opt.uv_enable &&
                  ((supply_warning_irq_enable && sw_toggle) ||
                   (ie_rise && (sw_flag || sw_missed || sw_toggle)));
    end

    // Flag follows the comparator; the pending bit clears on routine entry.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_flag            <= 1'b0;
            supply_warning_irq <= 1'b0;
        end else begin
            sw_flag <= sw_new;
            if (irq_set) begin
                supply_warning_irq <= 1'b1;
            end else if (isr_ack_i) begin
                supply_warning_irq <= 1'b0;
            end
        end
    end

    // Remember a crossing made while the interrupt was off, so that a later
    // enable still reports it; a fresh crossing wins over the clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_missed <= 1'b0;
        end else if (opt.uv_enable && !supply_warning_irq_enable && sw_toggle &&
                     !ie_rise) begin
            sw_missed <= 1'b1;
        end else if (!opt.uv_enable || supply_warning_irq_enable) begin
            sw_missed <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // Enable bit and option settings; options survive sequence restarts.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            supply_warning_irq_enable <= 1'b0;
            opt <= rssm_opt_t'(`RSSM_OPT_RESET);
        end else if (wr_en && w_lane0) begin
            if (aw_addr == `RSSM_OFS_ICS) begin
                supply_warning_irq_enable <= w_data[`RSSM_ICS_IE];
            end
            if (aw_addr == `RSSM_OFS_OPT) begin
                opt <= rssm_opt_t'(w_data);
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    // Address and data are taken in either order and held; the answer
    // follows one cycle after both are held.
    assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RSSM_RESP_OKAY;
            aw_addr       <= 8'h00;
            w_data        <= 8'h00;
            w_lane0       <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data       <= s_axi_wdata[7:0];
                w_lane0      <= s_axi_wstrb[0];
            end
            if (wr_en) begin
                s_axi_bvalid <= 1'b1;
                // The phase register is read-only; other holes are unmapped.
                s_axi_bresp  <= (aw_addr == `RSSM_OFS_ICS ||
                                 aw_addr == `RSSM_OFS_OPT)
                                ? `RSSM_RESP_OKAY : `RSSM_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    // Decode the read address; reserved bits read as zero.
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `RSSM_OFS_ICS: begin
                rd_val[`RSSM_ICS_IE]    = supply_warning_irq_enable;
                rd_val[`RSSM_ICS_FLAG]  = sw_flag;
                rd_val[`RSSM_ICS_UVRF]  = uv_rf;
                rd_val[`RSSM_ICS_WATCHDOG_RESET_FLAG] = wdg_rf;
            end
            `RSSM_OFS_OPT:   rd_val[7:0] = opt;
            `RSSM_OFS_PHASE: rd_val[1:0] = phase;
            default:         rd_hit = 1'b0;
        endcase
    end

    // One read at a time; data registered in the accepting cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RSSM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= rd_hit ? `RSSM_RESP_OKAY : `RSSM_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_pin_low_in_delay;
        (phase == RSSM_DELAY) |-> rst_pin_oe && !rst_pin_o;
    endproperty
    a_pin_low_in_delay: assert property (p_pin_low_in_delay)
        else $error("reset pin released during delay");

    property p_fetch_two;
        (phase == RSSM_DELAY && next_phase == RSSM_FETCH) ##1 !any_src
            |=> vec_fetch && vec_addr == `RSSM_VEC_HI ##1 !vec_fetch;
    endproperty
    a_fetch_two: assert property (p_fetch_two)
        else $error("vector fetch not two cycles");

    property p_delay_load;
        (phase == RSSM_ACTIVE && next_phase == RSSM_DELAY)
            |=> cnt == $past(delay_len);
    endproperty
    a_delay_load: assert property (p_delay_load)
        else $error("delay counter loaded wrong");

    property p_uv_static;
        src_uv |=> phase == RSSM_ACTIVE && rst_pin_oe && uv_rf;
    endproperty
    a_uv_static: assert property (p_uv_static)
        else $error("undervoltage did not hold reset");

    property p_wdg_pulse;
        wdg_underflow_i |=> rst_pin_oe [*8];
    endproperty
    a_wdg_pulse: assert property (p_wdg_pulse)
        else $error("watchdog pulse too short");

    property p_wdg_flag_clear;
        (src_uv && !wdg_underflow_i) |=> !wdg_rf;
    endproperty
    a_wdg_flag_clear: assert property (p_wdg_flag_clear)
        else $error("watchdog flag survived undervoltage");

    property p_toggle_irq;
        (opt.uv_enable && supply_warning_irq_enable && phase == RSSM_RUN &&
         sw_new != sw_flag) |=> supply_warning_irq;
    endproperty
    a_toggle_irq: assert property (p_toggle_irq)
        else $error("flag toggle raised no interrupt");

    property p_no_warn_disabled;
        !opt.uv_enable |=> !sw_flag && ($stable(supply_warning_irq) || !supply_warning_irq);
    endproperty
    a_no_warn_disabled: assert property (p_no_warn_disabled)
        else $error("warning active with detector off");

    property p_ack_clears;
        (isr_ack_i && !irq_set) |=> !supply_warning_irq;
    endproperty
    a_ack_clears: assert property (p_ack_clears)
        else $error("pending interrupt not cleared");

    property p_restart;
        (phase != RSSM_ACTIVE && any_src) |=> phase == RSSM_ACTIVE && rst_pin_oe;
    endproperty
    a_restart: assert property (p_restart)
        else $error("source did not restart the sequence");

endmodule // rssm_top

// *** dv/rssm_rst_partner.sv ***
// Far side of the reset pad: an external reset circuit and the pull-up.
// Assumes the device shows its pad value and enable.
`timescale 1ns/1ps
module rssm_rst_partner (
    input  wire logic dev_o,
    input  wire logic dev_oe,
    input  wire logic ext_pull,
    output logic      pad
);
    // Open drain: any low driver wins, else the weak pull-up gives 1.
    assign pad = (dev_oe ? dev_o : 1'b1) & ~ext_pull;
endmodule // rssm_rst_partner

// *** dv/tb.sv ***
// Self-checking bench of the reset sequencer and supply monitor.
// Assumes the design package, its header and the pad partner.
`timescale 1ns/1ps
`include "rssm_params.svh"
module tb
    import rssm_pkg::*;
;
    localparam int DS = 4;
    localparam int DL = 16;
    logic aclk = 1'b0;
    logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, pin_i, pin_o, pin_oe, uv, sw, wdg, ack, ext, cpu_n, vf, osc, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd, seed;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs, uvt;
    logic [2:0] css;
    logic [15:0] va;
    int n_mismatch, checks, h;
    always #4 aclk = ~aclk;
    rssm_rst_partner i_pad (.dev_o(pin_o), .dev_oe(pin_oe), .ext_pull(ext), .pad(pin_i));
    rssm_top #(.DELAY_SHORT(DS), .DELAY_LONG(DL)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .rst_pin_i(pin_i), .rst_pin_o(pin_o), .rst_pin_oe(pin_oe), .uv_low_i(uv),
        .sw_cmp_i(sw), .wdg_underflow_i(wdg), .isr_ack_i(ack), .cpu_reset_n(cpu_n),
        .vec_fetch(vf), .vec_addr(va), .osc_run(osc), .clock_source_selector(css),
        .uv_threshold_sel(uvt), .supply_warning_irq(irq));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // A wait that ran out counts as a mismatch and ends the run.
    task automatic hang();
        n_mismatch++;
        report_and_stop();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        {awvalid, wvalid, bready} <= 3'b111;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rs = bresp;
        bready <= 1'b0;
        if (i == 50) hang();
    endtask
    task automatic rd_reg(input logic [7:0] a);
        int i;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (i == 50) hang();
    endtask
    // Fires sources src for hold cycles, then times pad drive and vector fetch.
    task automatic seq(input logic [2:0] src, input int hold, input int lo, input logic ex);
        int i, n;
        n = 0;
        fork
            begin
                {uv, ext, wdg} <= src;
                repeat (hold) @(posedge aclk);
                {uv, ext, wdg} <= 3'b000;
            end
        join_none
        for (i = 0; i < 100 && !pin_oe; i++) @(posedge aclk);
        if (i == 100) hang();
        for (i = 0; i < 300 && pin_oe; i++) begin
            chk(cpu_n, 1'b0);
            n++;
            @(posedge aclk);
        end
        if (i == 300) hang();
        chk(ex ? 32'(n) : 32'(n >= lo), ex ? 32'(lo) : 32'd1);
        chk({vf, va}, {1'b1, `RSSM_VEC_LO});
        @(posedge aclk);
        chk({vf, va}, {1'b1, `RSSM_VEC_HI});
        @(posedge aclk);
        chk({vf, cpu_n}, 2'b01);
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, uv, sw, wdg, ack, ext} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        seed = 67;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        seq(3'b000, 1, DS, 1'b0);
        rd_reg(`RSSM_OFS_OPT);
        chk(rd, 32'h0000_0012);
        chk({osc, css}, 4'h9);
        wr(`RSSM_OFS_PHASE, 32'h0000_0000);
        chk(rs, `RSSM_RESP_SLVERR);
        rd_reg(`RSSM_OFS_PHASE);
        chk(rd, 32'h0000_0003);
        rd_reg(8'h0c);
        chk(rs, `RSSM_RESP_SLVERR);
        $display("test registers done");
        seq(3'b001, 1, 25 + DS, 1'b0);
        rd_reg(`RSSM_OFS_ICS);
        chk(rd[0], 1'b1);
        h = 1 + int'(xs() % 8);
        seq(3'b100, h, h + DS, 1'b0);
        rd_reg(`RSSM_OFS_ICS);
        chk({rd[4], rd[0]}, 2'b10);
        seq(3'b010, 1, 1 + DS, 1'b1);
        rd_reg(`RSSM_OFS_ICS);
        chk({rd[4], rd[0]}, 2'b10);
        wr(`RSSM_OFS_OPT, 32'h0000_001b | (xs() & 32'h0000_0080));
        chk(rs, `RSSM_RESP_OKAY);
        seq(3'b010, 1, 1 + DL, 1'b1);
        chk({css, uvt}, 5'h06);
        ext <= 1'b1;
        @(posedge aclk);
        ext <= 1'b0;
        repeat (8) @(posedge aclk);
        seq(3'b001, 1, 25 + DL, 1'b0);
        wr(`RSSM_OFS_ICS, 32'h0000_0000);
        rd_reg(`RSSM_OFS_ICS);
        chk(rd[4:0], 5'h00);
        $display("test reset sources done");
        sw <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(irq, 1'b0);
        wr(`RSSM_OFS_ICS, 32'h0000_0040);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b1);
        rd_reg(`RSSM_OFS_ICS);
        chk(rd[6:5], 2'b11);
        ack <= 1'b1;
        @(posedge aclk);
        ack <= 1'b0;
        sw <= 1'b0;
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        repeat (6) @(posedge aclk);
        chk(irq, 1'b1);
        wr(`RSSM_OFS_ICS, 32'h0000_0000);
        {ack, sw} <= 2'b11;
        repeat (6) @(posedge aclk);
        {ack, sw} <= 2'b00;
        repeat (6) @(posedge aclk);
        chk(irq, 1'b0);
        wr(`RSSM_OFS_ICS, 32'h0000_0040);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b1);
        ack <= 1'b1;
        @(posedge aclk);
        ack <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(irq, 1'b0);
        wr(`RSSM_OFS_OPT, 32'h0000_0010);
        ack <= 1'b1;
        sw <= 1'b1;
        @(posedge aclk);
        ack <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(irq, 1'b0);
        $display("test warning done");
        report_and_stop();
    end
endmodule // tb
